/* File: rtl/dhss_pkg.sv */
// Purpose: Shared constants for the dual hot-swap sequencer.
// Assumes: A 50 MHz system clock (20 ns period).
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package dhss_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned TMR_W           = 22;
  localparam int unsigned CNT_W           = 21;
  localparam int unsigned RETRY_W         = 7;

  localparam int unsigned START_DEF_US    = 9000;
  localparam int unsigned START_MAX_US    = 50000;
  localparam int unsigned LOCK_DELAY_US   = 37500;
  localparam int unsigned PG_DELAY_US     = 750;
  localparam int unsigned UNLATCH_US      = 100;
  localparam int unsigned RETRY_PERIODS   = 64;

  // Least times round up, the longest time rounds down.
  localparam int unsigned START_DEF_CYC   =
    (START_DEF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned START_MAX_CYC   =
    (START_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned LOCK_DELAY_CYC  =
    (LOCK_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PG_DELAY_CYC    =
    (PG_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UNLATCH_CYC     =
    (UNLATCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] CH_NONE          = 2'h0;
  localparam logic [1:0] CH_BOTH          = 2'h3;

  typedef enum logic [4:0] {
    ST_WAIT  = 5'h01,
    ST_START = 5'h02,
    ST_PGDLY = 5'h04,
    ST_RUN   = 5'h08,
    ST_FAULT = 5'h10
  } dhss_state_t;

endpackage

/* File: rtl/dhss_timer_if.sv */
// Purpose: Carries a load-and-run request to the period timer.
// Assumes: One clock domain shared by both ends.
// Notes:   Done is a one-cycle pulse.
`timescale 1ns/1ps
interface dhss_timer_if;
  logic                            start;
  logic [dhss_pkg::TMR_W-1:0]      len;
  logic                            done;

  modport ctl (output start, output len, input done);
  modport tmr (input start, input len, output done);
endinterface

/* File: rtl/dhss_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are levels that stay steady for several clocks.
// Notes:   The first stage feeds only the second one.
`timescale 1ns/1ps
module dhss_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

/* File: rtl/dhss_timer.sv */
// Purpose: Down-counting period timer with a one-cycle done pulse.
// Assumes: A length of at least one cycle.
// Notes:   A new start restarts a running count.
`timescale 1ns/1ps
module dhss_timer (
  input  wire logic  clk_sys_i,
  input  wire logic  rst_b_i,
  dhss_timer_if.tmr  tif
);

  logic [dhss_pkg::TMR_W-1:0] cnt;
  logic                       run;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt      <= '0;
      run      <= 1'b0;
      tif.done <= 1'b0;
    end else begin
      tif.done <= 1'b0;
      if (tif.start) begin
        cnt <= tif.len;
        run <= 1'b1;
      end else if (run) begin
        cnt <= cnt - 1'b1;
        if (cnt <= 1) begin
          run      <= 1'b0;
          tif.done <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: rtl/dhss_top.sv */
// Purpose: Sequences and supervises two hot-swap power channels.
// Assumes: Comparator results arrive as digital pins, high when tripped.
// Notes:   PROTECT picks protection or monitoring, AUTORETRY picks restart.
`timescale 1ns/1ps
module dhss_top #(
  parameter bit          PROTECT        = 1'b1,
  parameter bit          AUTORETRY      = 1'b0,
  parameter int unsigned START_DEF_CYC  = dhss_pkg::START_DEF_CYC,
  parameter int unsigned START_MAX_CYC  = dhss_pkg::START_MAX_CYC,
  parameter int unsigned LOCK_DELAY_CYC = dhss_pkg::LOCK_DELAY_CYC,
  parameter int unsigned PG_DELAY_CYC   = dhss_pkg::PG_DELAY_CYC,
  parameter int unsigned UNLATCH_CYC    = dhss_pkg::UNLATCH_CYC
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       supply1_above_lockout_i,
  input  wire logic                       supply2_above_lockout_i,
  input  wire logic                       ch1_on_request_i,
  input  wire logic                       ch2_on_request_i,
  input  wire logic                       ch1_current_sense_fast_i,
  input  wire logic                       ch2_current_sense_fast_i,
  input  wire logic                       ch1_current_sense_slow_i,
  input  wire logic                       ch2_current_sense_slow_i,
  input  wire logic                       ch1_output_window_monitor_i,
  input  wire logic                       ch2_output_window_monitor_i,
  input  wire logic                       startup_timer_open_i,
  input  wire logic [dhss_pkg::TMR_W-1:0] startup_timer_setting_i,
  output logic                            ch1_gate_drive_o,
  output logic                            ch2_gate_drive_o,
  output logic                            ch1_gate_limited_o,
  output logic                            ch2_gate_limited_o,
  output logic                            ch1_startup_limit_threshold_o,
  output logic                            ch2_startup_limit_threshold_o,
  output logic                            ch1_power_good_status_o,
  output logic                            ch1_power_good_status_oe_o,
  output logic                            ch2_power_good_status_o,
  output logic                            ch2_power_good_status_oe_o
);

  localparam int unsigned SYNC_W = 11 + dhss_pkg::TMR_W;
  localparam int unsigned TW     = dhss_pkg::TMR_W;
  localparam int unsigned CW     = dhss_pkg::CNT_W;
  localparam int unsigned RW     = dhss_pkg::RETRY_W;

  localparam logic [TW-1:0] DEF_LEN  = TW'(START_DEF_CYC);
  localparam logic [TW-1:0] MAX_LEN  = TW'(START_MAX_CYC);
  localparam logic [TW-1:0] PG_LEN   = TW'(PG_DELAY_CYC);
  localparam logic [CW-1:0] LOCK_MAX = CW'(LOCK_DELAY_CYC);
  localparam logic [CW-1:0] UNL_MAX  = CW'(UNLATCH_CYC);
  localparam logic [RW-1:0] RETRY_LAST =
    RW'(dhss_pkg::RETRY_PERIODS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  logic [SYNC_W-1:0]       sync_raw;
  logic [SYNC_W-1:0]       sync_q;
  logic [1:0]              sup_s;
  logic [1:0]              on_s;
  logic [1:0]              fast_s;
  logic [1:0]              slow_s;
  logic [1:0]              win_s;
  logic                    tim_open_s;
  logic [TW-1:0]           tim_set_s;

  assign sync_raw = {startup_timer_setting_i, startup_timer_open_i,
                     ch2_output_window_monitor_i, ch1_output_window_monitor_i,
                     ch2_current_sense_slow_i, ch1_current_sense_slow_i,
                     ch2_current_sense_fast_i, ch1_current_sense_fast_i,
                     ch2_on_request_i, ch1_on_request_i,
                     supply2_above_lockout_i, supply1_above_lockout_i};

  dhss_sync #(.W(SYNC_W)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (sync_raw),
    .sync_o    (sync_q)
  );

  assign sup_s      = sync_q[1:0];
  assign on_s       = sync_q[3:2];
  assign fast_s     = sync_q[5:4];
  assign slow_s     = sync_q[7:6];
  assign win_s      = sync_q[9:8];
  assign tim_open_s = sync_q[10];
  assign tim_set_s  = sync_q[SYNC_W-1:11];

  ////////////////////////////////////////////////////////////////////////////
  // Startup period length and the shared period timer.

  logic [TW-1:0] start_len;
  dhss_timer_if  tif ();

  dhss_timer u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .tif       (tif)
  );

  // A zero setting counts as one cycle; the timer would also end a zero length after one cycle.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_len <= DEF_LEN;
    end else if (tim_open_s) begin
      start_len <= DEF_LEN;
    end else if (tim_set_s > MAX_LEN) begin
      start_len <= MAX_LEN;
    end else if (tim_set_s == '0) begin
      start_len <= TW'(1);
    end else begin
      start_len <= tim_set_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lockout qualification and unlatch toggle detection.

  logic [CW-1:0] lock_cnt;
  logic [CW-1:0] on_low_cnt;
  logic [1:0]    sup_back;
  logic          lock_ok;
  logic          on_unl;
  logic          sup_unl;

  // Only a drop of both supplies restarts the qualifying delay.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_cnt <= '0;
    end else if (sup_s == dhss_pkg::CH_NONE) begin
      lock_cnt <= '0;
    end else if (lock_cnt != LOCK_MAX) begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      on_low_cnt <= '0;
    end else if (on_s == dhss_pkg::CH_BOTH) begin
      on_low_cnt <= '0;
    end else if (on_low_cnt != UNL_MAX) begin
      on_low_cnt <= on_low_cnt + 1'b1;
    end
  end

  // Each rail is watched on its own, so one rail cycled through lockout
  // clears the latch even while the other rail never came up at all.
  for (genvar g = 0; g < 2; g++) begin : g_sup
    logic [CW-1:0] low_cnt;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        low_cnt <= '0;
      end else if (sup_s[g]) begin
        low_cnt <= '0;
      end else if (low_cnt != UNL_MAX) begin
        low_cnt <= low_cnt + 1'b1;
      end
    end

    assign sup_back[g] = sup_s[g] && (low_cnt == UNL_MAX);
  end

  // A toggle counts once the low time is served and the level is back.
  assign lock_ok = (lock_cnt == LOCK_MAX);
  assign on_unl  = (on_low_cnt == UNL_MAX) && (on_s == dhss_pkg::CH_BOTH);
  assign sup_unl = |sup_back;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // Gates may conduct only in the startup, delay and run states.
  function automatic logic is_live(input dhss_pkg::dhss_state_t s);
    return (s == dhss_pkg::ST_START) || (s == dhss_pkg::ST_PGDLY) ||
           (s == dhss_pkg::ST_RUN);
  endfunction

  // Fault supervision starts only once the startup period is over.
  function automatic logic is_watched(input dhss_pkg::dhss_state_t s);
    return (s == dhss_pkg::ST_PGDLY) || (s == dhss_pkg::ST_RUN);
  endfunction

  dhss_pkg::dhss_state_t state;
  dhss_pkg::dhss_state_t next_state;
  logic [RW-1:0]         retry_cnt;
  logic                  oc_seen;
  logic                  win_seen;
  logic                  start_ok;
  logic                  retry_over;
  logic                  unlatch;

  assign oc_seen    = |(fast_s | slow_s);
  assign win_seen   = PROTECT && (win_s != dhss_pkg::CH_NONE);
  assign start_ok   = lock_ok && (on_s == dhss_pkg::CH_BOTH);
  assign retry_over = AUTORETRY && tif.done &&
                      (retry_cnt == RETRY_LAST);

  // Toggling an on request does not cut an autoretry delay short.
  assign unlatch = sup_unl || (!AUTORETRY && on_unl);

  always_comb begin
    next_state = state;
    unique case (state)
      dhss_pkg::ST_WAIT: begin
        if (start_ok) begin
          next_state = dhss_pkg::ST_START;
        end
      end
      dhss_pkg::ST_START: begin
        // Fast trips only regulate here; no current trip raises a fault.
        if (!start_ok) begin
          next_state = dhss_pkg::ST_WAIT;
        end else if (tif.done) begin
          next_state = dhss_pkg::ST_PGDLY;
        end
      end
      dhss_pkg::ST_PGDLY: begin
        if (oc_seen || win_seen) begin
          next_state = dhss_pkg::ST_FAULT;
        end else if (!start_ok) begin
          next_state = dhss_pkg::ST_WAIT;
        end else if (tif.done) begin
          next_state = dhss_pkg::ST_RUN;
        end
      end
      dhss_pkg::ST_RUN: begin
        if (oc_seen || win_seen) begin
          next_state = dhss_pkg::ST_FAULT;
        end else if (!start_ok) begin
          next_state = dhss_pkg::ST_WAIT;
        end
      end
      dhss_pkg::ST_FAULT: begin
        if (unlatch || retry_over) begin
          next_state = dhss_pkg::ST_WAIT;
        end
      end
      default: begin
        next_state = dhss_pkg::ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= dhss_pkg::ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // The one timer serves startup, power-good delay and retry periods.
  always_comb begin
    tif.start = 1'b0;
    tif.len   = start_len;
    if (next_state != state) begin
      tif.start = (next_state == dhss_pkg::ST_START) ||
                  (next_state == dhss_pkg::ST_PGDLY) ||
                  (next_state == dhss_pkg::ST_FAULT);
    end else if ((state == dhss_pkg::ST_FAULT) && tif.done) begin
      tif.start = AUTORETRY;
    end
    if (next_state == dhss_pkg::ST_PGDLY) begin
      tif.len = PG_LEN;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      retry_cnt <= '0;
    end else if (state != dhss_pkg::ST_FAULT) begin
      retry_cnt <= '0;
    end else if (tif.done && (retry_cnt != RETRY_LAST)) begin
      retry_cnt <= retry_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel outputs.

  logic [1:0] gate_q;
  logic [1:0] lim_q;
  logic [1:0] thr_q;
  logic [1:0] oe_q;
  logic       pg_lvl;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic gate_r;
    logic lim_r;
    logic thr_r;
    logic oe_r;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        gate_r <= 1'b0;
      end else begin
        gate_r <= is_live(next_state) && on_s[c];
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        lim_r <= 1'b0;
      end else begin
        lim_r <= (next_state == dhss_pkg::ST_START) && on_s[c];
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        thr_r <= 1'b0;
      end else begin
        thr_r <= (next_state == dhss_pkg::ST_START) && on_s[c] &&
                 fast_s[c];
      end
    end

    // Reset pulls low, so the pin never shows good before a startup.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        oe_r <= 1'b1;
      end else begin
        oe_r <= !((next_state == dhss_pkg::ST_RUN) && on_s[c] &&
                  !win_s[c]);
      end
    end

    assign gate_q[c] = gate_r;
    assign lim_q[c]  = lim_r;
    assign thr_q[c]  = thr_r;
    assign oe_q[c]   = oe_r;
  end

  // The pin only ever sinks; the board pull-up makes the high level.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pg_lvl <= 1'b0;
    end else begin
      pg_lvl <= 1'b0;
    end
  end

  assign ch1_gate_drive_o              = gate_q[0];
  assign ch2_gate_drive_o              = gate_q[1];
  assign ch1_gate_limited_o            = lim_q[0];
  assign ch2_gate_limited_o            = lim_q[1];
  assign ch1_startup_limit_threshold_o = thr_q[0];
  assign ch2_startup_limit_threshold_o = thr_q[1];
  assign ch1_power_good_status_o       = pg_lvl;
  assign ch2_power_good_status_o       = pg_lvl;
  assign ch1_power_good_status_oe_o    = oe_q[0];
  assign ch2_power_good_status_oe_o    = oe_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence oc_watched_s;
    is_watched(state) && oc_seen;
  endsequence

  sequence both_off_s;
    (state == dhss_pkg::ST_FAULT) && !ch1_gate_drive_o && !ch2_gate_drive_o;
  endsequence

  property oc_shut_p;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    oc_watched_s |=> both_off_s;
  endproperty

  oc_shut_a: assert property (oc_shut_p)
    else $error("overcurrent left a gate on");

  pg_hold_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (state != dhss_pkg::ST_RUN) |->
      (ch1_power_good_status_oe_o && ch2_power_good_status_oe_o))
    else $error("power good released outside run");

  gate_req_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (ch1_gate_drive_o |-> $past(on_s[0])) and
    (ch2_gate_drive_o |-> $past(on_s[1])))
    else $error("gate on without its on request");

  lim_start_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (ch1_gate_limited_o || ch2_gate_limited_o) |->
      (state == dhss_pkg::ST_START))
    else $error("limited charge outside startup");

  reg_start_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    ch1_startup_limit_threshold_o |->
      ((state == dhss_pkg::ST_START) && $past(fast_s[0])))
    else $error("gate regulation without a fast trip");

  slow_ignore_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (state == dhss_pkg::ST_START) |=> (state != dhss_pkg::ST_FAULT))
    else $error("fault raised during startup");

  win_protect_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (PROTECT && is_watched(state) && (win_s != dhss_pkg::CH_NONE)) |=>
      both_off_s)
    else $error("window fault left a gate on");

  win_monitor_a: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    (!PROTECT && (state == dhss_pkg::ST_RUN) && win_s[0]) |=>
      ch1_power_good_status_oe_o)
    else $error("window fault kept power good high");

endmodule

/* File: sim/dhss_load_model.sv */
// Purpose: Far-side model of the sense comparators and output monitors.
// Assumes: Comparators trip only while the channel's gate is driven.
// Notes:   The bench commands the faults; the model gates them.
`timescale 1ns/1ps
module dhss_load_model (
  input  wire logic [1:0] gate_i,
  input  wire logic [1:0] short_i,
  input  wire logic [1:0] over_i,
  input  wire logic [1:0] window_bad_i,
  output logic      [1:0] fast_o,
  output logic      [1:0] slow_o,
  output logic      [1:0] mon_o
);
  // An unpowered output draws no current, so only a live gate can trip.
  assign fast_o = gate_i & short_i;
  assign slow_o = gate_i & over_i;
  assign mon_o  = gate_i & window_bad_i;
endmodule

/* File: sim/dhss_top_bench.sv */
// Purpose: Self-checking bench for the dual hot-swap sequencer.
// Assumes: Protection variant with latched faults; short counts.
// Notes:   Power-good levels include the open-drain pull-up.
`timescale 1ns/1ps
module dhss_top_bench;
  localparam int unsigned DEF = 40;
  localparam int unsigned LK  = 30;
  localparam int unsigned PGD = 15;
  localparam int unsigned UNL = 10;
  logic clk_sys_i = 0, rst_b_i = 0, armed = 0, open = 1;
  logic [1:0] sup = 0, on = 2'h3, sh = 0, ov = 0, wb = 0;
  logic [1:0] fast, slow, mon, gate, lim, thr, pgo, pgoe, pg, last;
  logic [21:0] tset = 0;
  logic [1:0] q[$];
  int failures = 0, n_compared = 0, cyc = 0, t0, seed = 38;
  assign pg[0] = pgoe[0] ? pgo[0] : 1'b1;
  assign pg[1] = pgoe[1] ? pgo[1] : 1'b1;
  initial forever #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  dhss_load_model model (.gate_i(gate), .short_i(sh), .over_i(ov),
    .window_bad_i(wb), .fast_o(fast), .slow_o(slow), .mon_o(mon));
  dhss_top #(.START_DEF_CYC(DEF), .LOCK_DELAY_CYC(LK), .PG_DELAY_CYC(PGD),
    .UNLATCH_CYC(UNL)) uut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .supply1_above_lockout_i(sup[0]), .supply2_above_lockout_i(sup[1]),
    .ch1_on_request_i(on[0]), .ch2_on_request_i(on[1]),
    .ch1_current_sense_fast_i(fast[0]), .ch2_current_sense_fast_i(fast[1]),
    .ch1_current_sense_slow_i(slow[0]), .ch2_current_sense_slow_i(slow[1]),
    .ch1_output_window_monitor_i(mon[0]),
    .ch2_output_window_monitor_i(mon[1]),
    .startup_timer_open_i(open), .startup_timer_setting_i(tset),
    .ch1_gate_drive_o(gate[0]), .ch2_gate_drive_o(gate[1]),
    .ch1_gate_limited_o(lim[0]), .ch2_gate_limited_o(lim[1]),
    .ch1_startup_limit_threshold_o(thr[0]),
    .ch2_startup_limit_threshold_o(thr[1]),
    .ch1_power_good_status_o(pgo[0]), .ch1_power_good_status_oe_o(pgoe[0]),
    .ch2_power_good_status_o(pgo[1]), .ch2_power_good_status_oe_o(pgoe[1]));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [1:0] seen,
                       input logic [1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wait_pg(input logic [1:0] e, input int n);
    for (int i = 0; i < n && pg !== e; i++) @(negedge clk_sys_i);
    check("power good wait", pg, e);
  endtask
  // Levels are sampled mid-cycle so both channels have settled together.
  always @(negedge clk_sys_i) begin
    if (armed && pg !== last) begin
      if (q.size() == 0) check("unexpected power good", pg, last);
      else check("power good", pg, q.pop_front());
    end
    last <= pg;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ticks(20);
    rst_b_i = 1;
    ticks(2);
    armed = 1;
    sup = 2'h1;
    t0 = cyc;
    ticks(LK + 10);
    sh = 2'h3;
    ov = 2'h3;
    wb = 2'h3;
    ticks(3);
    check("gates in startup", gate, 2'h3);
    check("limited charge", lim, 2'h3);
    check("regulation", thr, 2'h3);
    sh = 0;
    ov = 0;
    wb = 0;
    q.push_back(2'h3);
    wait_pg(2'h3, 400);
    check("first release late", {1'b0, cyc - t0 >= LK + DEF + PGD}, 2'h1);
    ticks(5 + $unsigned($random(seed)) % 8);
    q.push_back(2'h0);
    wb = 2'h1;
    wait_pg(2'h0, 30);
    check("gates window fault", gate, 2'h0);
    wb = 0;
    ticks(DEF + PGD + 10);
    check("still latched", pg, 2'h0);
    on[0] = 0;
    ticks(UNL + 5);
    check("gate with on low", gate[0], 2'h0);
    tset = 50 + $unsigned($random(seed)) % 30;
    open = 0;
    on[0] = 1;
    t0 = cyc;
    q.push_back(2'h3);
    wait_pg(2'h3, 600);
    check("set period", {1'b0, cyc - t0 >= tset + PGD}, 2'h1);
    ticks(5 + $unsigned($random(seed)) % 8);
    q.push_back(2'h0);
    ov = 2'h2;
    wait_pg(2'h0, 30);
    check("gates slow trip", gate, 2'h0);
    ov = 0;
    sup = 0;
    ticks(UNL + 5);
    sup = 2'h2;
    q.push_back(2'h3);
    wait_pg(2'h3, 800);
    ticks(5 + $unsigned($random(seed)) % 8);
    q.push_back(2'h0);
    sh = 2'h1;
    wait_pg(2'h0, 30);
    check("gates fast trip", gate, 2'h0);
    ticks(5);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    final_report();
  end
endmodule
